// *** src/insync_pkg.sv ***
// package: register map, reset values and timing constants of the input sync bank
package insync_pkg;
   // ****************************************
   // register byte offsets
   // ****************************************
   localparam logic [7:0] OFS_PDO_COUNT   = 8'h00;
   localparam logic [7:0] OFS_PDO_ENTRY   = 8'h04;
   localparam logic [7:0] OFS_SYNC_COUNT  = 8'h08;
   localparam logic [7:0] OFS_MODE        = 8'h0C;
   localparam logic [7:0] OFS_CYCLE       = 8'h10;
   localparam logic [7:0] OFS_SHIFT       = 8'h14;
   localparam logic [7:0] OFS_MODES_SUP   = 8'h18;
   localparam logic [7:0] OFS_MIN_CYCLE   = 8'h1C;
   localparam logic [7:0] OFS_CALC_COPY   = 8'h20;
   localparam logic [7:0] OFS_MIN_DELAY   = 8'h24;
   localparam logic [7:0] OFS_COMMAND     = 8'h28;
   localparam logic [7:0] OFS_MAX_DELAY   = 8'h2C;
   localparam logic [7:0] OFS_MISSED      = 8'h30;
   localparam logic [7:0] OFS_OVERRUN     = 8'h34;
   localparam logic [7:0] OFS_SHORT       = 8'h38;
   localparam logic [7:0] OFS_SYNC_ERR    = 8'h3C;
   localparam logic [7:0] OFS_IRQ_STATUS  = 8'h40;
   localparam logic [7:0] OFS_IRQ_MASK    = 8'h44;
   // ****************************************
   // reset values
   // ****************************************
   localparam logic [7:0]  RST_PDO_COUNT  = 8'h01;
   localparam logic [15:0] RST_PDO_ENTRY  = 16'h1A00;
   localparam logic [7:0]  RST_SYNC_COUNT = 8'h20;
   localparam logic [15:0] RST_MODE       = 16'h0000;
   localparam logic [31:0] RST_CYCLE      = 32'h000F4240;
   localparam logic [31:0] RST_SHIFT      = 32'h00000384;
   localparam logic [15:0] RST_MODES_SUP  = 16'h8001;
   localparam logic [31:0] RST_MIN_CYCLE  = 32'h00002710;
   localparam logic [31:0] RST_CALC_COPY  = 32'h00000000;
   localparam logic [31:0] RST_MIN_DELAY  = 32'h00000384;
   localparam logic [15:0] RST_COMMAND    = 16'h0000;
   localparam logic [31:0] RST_MAX_DELAY  = 32'h00000384;
   // ****************************************
   // sync mode codes and commands
   // ****************************************
   localparam logic [15:0] MODE_FREE_RUN  = 16'h0000;
   localparam logic [15:0] MODE_SM_IN     = 16'h0001;
   localparam logic [15:0] MODE_DC_SYNC0  = 16'h0002;
   localparam logic [15:0] MODE_DC_SYNC1  = 16'h0003;
   localparam logic [15:0] MODE_SM_OUT    = 16'h0022;
   localparam logic [15:0] CMD_STOP       = 16'h0000;
   localparam logic [15:0] CMD_START      = 16'h0001;
   // ****************************************
   // interrupt status bit positions
   // ****************************************
   localparam int IRQ_MISSED   = 0;
   localparam int IRQ_OVERRUN  = 1;
   localparam int IRQ_SHORT    = 2;
   localparam int IRQ_SYNC_ERR = 3;
   localparam int IRQ_W        = 4;
   // ****************************************
   // timing
   // ****************************************
   localparam int CLK_PERIOD_NS = 10;
   localparam logic [31:0] NS_PER_CLK = 32'h0000000A;
endpackage

// *** src/insync_apb_slave.sv ***
// module: apb slave front end, decodes one register access per transfer
`timescale 1ns/10ps
module insync_apb_slave (
   input  wire logic        clk_i,     // system clock
   input  wire logic        rst_i,     // synchronous reset, active high
   input  wire logic        psel,      // apb select
   input  wire logic        penable,   // apb access phase
   input  wire logic        pwrite,    // apb direction
   input  wire logic [7:0]  paddr,     // apb byte address
   output logic             pready,    // apb ready, always one cycle access
   output logic             wr_o,      // write strobe, one cycle
   output logic             rd_o,      // read strobe, one cycle
   output logic [7:0]       addr_o     // word-aligned address for the bank
);
   // zero wait states: every access completes in its first access cycle
   assign pready = 1'b1;
   always_comb begin
      wr_o   = psel & penable & pwrite;
      rd_o   = psel & penable & ~pwrite;
      addr_o = {paddr[7:2], 2'b00};
   end
endmodule

// *** src/input_sync_parameter_bank.sv ***
// module: input synchronisation parameter and diagnostic register bank
`timescale 1ns/10ps
// Contract
// - sync mode 16-bit rw, reset free run
// - cycle time in ns, resets 1 ms
// - shift time reports 900 ns default
// - supported modes bitmap reads 0x8001
// - bits 4-5 encode input shift source
// - minimum cycle time reads 10000 ns
// - calc and copy time defaults zero
// - command 1 starts, 0 stops measurement
// - measuring keeps maxima, cleared on start
// - sync1 to sampling delay defaults 900
// - count missed sm events, dc operational
// - count overrun cycles in operational
// - count too short sync0-sync1 spacing in dc mode
// - sync error flag on late outputs in dc mode
// - one input assignment entry, 0x1A00
// - highest subindex reads 0x20
module input_sync_parameter_bank (
   input  wire logic        clk_i,          // system clock, 100 MHz
   input  wire logic        rst_i,          // synchronous reset, active high
   input  wire logic        psel,           // apb select
   input  wire logic        penable,        // apb enable
   input  wire logic        pwrite,         // apb write
   input  wire logic [7:0]  paddr,          // apb address
   input  wire logic [31:0] pwdata,         // apb write data
   output logic [31:0]      prdata,         // apb read data
   output logic             pready,         // apb ready
   output logic             pslverr,        // apb error on unmapped address
   input  wire logic        op_state_i,     // device is operational (pin)
   input  wire logic        sync0_i,        // first dc event (pin)
   input  wire logic        sync1_i,        // second dc event (pin)
   input  wire logic        sm_event_i,     // sync manager event (pin)
   input  wire logic        sample_i,       // input sampling done (pin)
   input  wire logic        avail_i,        // inputs available to master (pin)
   input  wire logic        out_late_i,     // outputs driven too late (pin)
   output logic             measuring_o,    // cycle measurement running
   output logic             irq_o           // level interrupt
);
   // ****************************************
   // state
   // ****************************************
   localparam int IRQ_W_L = insync_pkg::IRQ_W;
   typedef struct packed {
      logic [2:0]  op_s;          // synchroniser, op state
      logic [2:0]  s0_s;          // synchroniser + edge history, sync0
      logic [2:0]  s1_s;          // sync1
      logic [2:0]  sm_s;          // sm event
      logic [2:0]  sa_s;          // sampling
      logic [2:0]  av_s;          // availability
      logic [2:0]  ol_s;          // outputs late
      logic [15:0] pdo_entry;     // assigned mapping index
      logic [15:0] mode;          // sync mode
      logic [31:0] cycle;         // cycle time ns
      logic [31:0] shift;         // sync0 to sampling ns
      logic [31:0] calc;          // sampling to availability ns
      logic [31:0] maxd;          // sync1 to sampling ns
      logic [15:0] cmd;           // measurement command
      logic [15:0] missed;        // missed sm events
      logic [15:0] overrun;       // overrun cycles
      logic [15:0] short_cnt;     // short sync0-sync1 spacings
      logic        sync_err;      // sync error flag
      logic [31:0] t0;            // ns since sync0
      logic [31:0] t1;            // ns since sync1
      logic [31:0] ts;            // ns since sampling
      logic [31:0] tc;            // ns since cycle start
      logic        sm_seen;       // sm event seen this cycle
      logic        started;       // a cycle boundary has been seen
      logic        dc_run;        // a dc cycle opened by sync0 is running
      logic [IRQ_W_L-1:0] irq_st; // sticky event bits
      logic [IRQ_W_L-1:0] irq_mk; // event mask
      logic [31:0] rdata;         // registered read data
   } st_t;
   st_t r_r, r_nxt;

   logic       wr, rd;            // bus strobes
   logic [7:0] addr;              // decoded address
   logic       op, s0, s1, sme, sa, av, ol; // synchronised edges / levels
   logic       dc;                // dc mode active
   logic       mapped;            // address hits a register

   insync_apb_slave u_apb (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .psel    (psel),
      .penable (penable),
      .pwrite  (pwrite),
      .paddr   (paddr),
      .pready  (pready),
      .wr_o    (wr),
      .rd_o    (rd),
      .addr_o  (addr)
   );

   // saturating add for the nanosecond timers, so a stalled link never wraps
   function automatic logic [31:0] tick(input logic [31:0] v);
      tick = (v > 32'hFFFFFFF5) ? v : v + insync_pkg::NS_PER_CLK;
   endfunction

   // saturating counter increment
   function automatic logic [15:0] inc16(input logic [15:0] v);
      inc16 = (v == 16'hFFFF) ? v : v + 16'h0001;
   endfunction

   // rising edge from stages 1 and 2 only; stage 0 feeds stage 1 alone
   function automatic logic rise(input logic [2:0] s);
      rise = s[1] & ~s[2];
   endfunction

   // ****************************************
   // decode
   // ****************************************
   always_comb begin
      op  = r_r.op_s[1];
      s0  = rise(r_r.s0_s);
      s1  = rise(r_r.s1_s);
      sme = rise(r_r.sm_s);
      sa  = rise(r_r.sa_s);
      av  = rise(r_r.av_s);
      ol  = rise(r_r.ol_s);
      dc  = (r_r.mode == insync_pkg::MODE_DC_SYNC0) | (r_r.mode == insync_pkg::MODE_DC_SYNC1);
      unique case (addr)
         insync_pkg::OFS_PDO_COUNT, insync_pkg::OFS_PDO_ENTRY, insync_pkg::OFS_SYNC_COUNT,
         insync_pkg::OFS_MODE, insync_pkg::OFS_CYCLE, insync_pkg::OFS_SHIFT,
         insync_pkg::OFS_MODES_SUP, insync_pkg::OFS_MIN_CYCLE, insync_pkg::OFS_CALC_COPY,
         insync_pkg::OFS_MIN_DELAY, insync_pkg::OFS_COMMAND, insync_pkg::OFS_MAX_DELAY,
         insync_pkg::OFS_MISSED, insync_pkg::OFS_OVERRUN, insync_pkg::OFS_SHORT,
         insync_pkg::OFS_SYNC_ERR, insync_pkg::OFS_IRQ_STATUS,
         insync_pkg::OFS_IRQ_MASK: mapped = 1'b1;
         default:                  mapped = 1'b0;
      endcase
   end

   // ****************************************
   // next state
   // ****************************************
   always_comb begin
      logic [IRQ_W_L-1:0] ev;     // events this cycle
      logic               start;  // measurement begins
      ev    = '0;
      r_nxt = r_r;
      start = 1'b0;
      // two-flop synchronisers plus one history stage
      r_nxt.op_s = {r_r.op_s[1:0], op_state_i};
      r_nxt.s0_s = {r_r.s0_s[1:0], sync0_i};
      r_nxt.s1_s = {r_r.s1_s[1:0], sync1_i};
      r_nxt.sm_s = {r_r.sm_s[1:0], sm_event_i};
      r_nxt.sa_s = {r_r.sa_s[1:0], sample_i};
      r_nxt.av_s = {r_r.av_s[1:0], avail_i};
      r_nxt.ol_s = {r_r.ol_s[1:0], out_late_i};
      // free running ns timers since the last events
      r_nxt.t0 = s0 ? '0 : tick(r_r.t0);
      r_nxt.t1 = s1 ? '0 : tick(r_r.t1);
      r_nxt.ts = sa ? '0 : tick(r_r.ts);
      r_nxt.tc = tick(r_r.tc);
      if (sme) begin
         r_nxt.sm_seen = 1'b1;
      end
      // leaving dc mode ends any open dc cycle
      if (!dc) begin
         r_nxt.dc_run = 1'b0;
      end
      // cycle boundary: sync0 in dc mode, else sm event or local timer
      if (dc ? s0 : (sme | (r_r.tc >= r_r.cycle))) begin
         r_nxt.tc = '0;
         // next cycle began too early, shorter than programmed
         if (op && r_r.started && (r_r.tc + 32'h00000014 < r_r.cycle)) begin
            ev[insync_pkg::IRQ_OVERRUN] = 1'b1;
         end
         // dc cycle ended with no sm event seen; only a cycle opened by
         // sync0 counts, so entering dc mode does not count a false miss
         if (dc && op && r_r.dc_run && !r_r.sm_seen && !sme) begin
            ev[insync_pkg::IRQ_MISSED] = 1'b1;
         end
         r_nxt.sm_seen = 1'b0;
         r_nxt.started = 1'b1;
         r_nxt.dc_run  = dc;
      end
      // cycle not finished: no new cycle boundary one clock after time ran out
      if (op && r_r.started && r_r.tc == r_r.cycle + insync_pkg::NS_PER_CLK) begin
         ev[insync_pkg::IRQ_OVERRUN] = 1'b1;
      end
      // sync1 too close to sync0: below the minimum delay figure
      if (dc && s1 && r_r.t0 < insync_pkg::RST_MIN_DELAY) begin
         ev[insync_pkg::IRQ_SHORT] = 1'b1;
      end
      if (dc && ol) begin
         ev[insync_pkg::IRQ_SYNC_ERR] = 1'b1;
      end
      if (ev[insync_pkg::IRQ_MISSED]) r_nxt.missed = inc16(r_r.missed);
      if (ev[insync_pkg::IRQ_OVERRUN]) r_nxt.overrun = inc16(r_r.overrun);
      if (ev[insync_pkg::IRQ_SHORT]) r_nxt.short_cnt = inc16(r_r.short_cnt);
      // flag shows the last cycle: refreshed at each sync0 in dc mode
      if (dc && s0) r_nxt.sync_err = 1'b0;
      if (ev[insync_pkg::IRQ_SYNC_ERR]) r_nxt.sync_err = 1'b1;
      // measurement keeps maxima of observed figures
      if (r_r.cmd == insync_pkg::CMD_START) begin
         if (sa && r_r.t0 > r_r.shift) r_nxt.shift = r_r.t0;
         if (sa && r_r.t1 > r_r.maxd) r_nxt.maxd = r_r.t1;
         if (av && r_r.ts > r_r.calc) r_nxt.calc = r_r.ts;
      end
      // register writes
      if (wr) begin
         unique case (addr)
            insync_pkg::OFS_PDO_ENTRY: r_nxt.pdo_entry = pwdata[15:0];
            insync_pkg::OFS_MODE:      r_nxt.mode = pwdata[15:0];
            insync_pkg::OFS_CYCLE:     r_nxt.cycle = pwdata;
            insync_pkg::OFS_COMMAND: begin
               r_nxt.cmd = pwdata[15:0];
               start = (pwdata[15:0] == insync_pkg::CMD_START) &&
                       (r_r.cmd != insync_pkg::CMD_START);
            end
            insync_pkg::OFS_IRQ_MASK:  r_nxt.irq_mk = pwdata[IRQ_W_L-1:0];
            insync_pkg::OFS_IRQ_STATUS: r_nxt.irq_st = r_r.irq_st & ~pwdata[IRQ_W_L-1:0];
            default: ;
         endcase
      end
      // a fresh measurement starts from cleared values
      if (start) begin
         r_nxt.shift = '0;
         r_nxt.calc  = '0;
         r_nxt.maxd  = '0;
      end
      // set wins over a write-one clear in the same cycle
      r_nxt.irq_st = r_nxt.irq_st | ev;
      // read data, captured at the access edge
      r_nxt.rdata = '0;
      if (rd) begin
         unique case (addr)
            insync_pkg::OFS_PDO_COUNT:  r_nxt.rdata = {24'h000000, insync_pkg::RST_PDO_COUNT};
            insync_pkg::OFS_PDO_ENTRY:  r_nxt.rdata = {16'h0000, r_r.pdo_entry};
            insync_pkg::OFS_SYNC_COUNT: r_nxt.rdata = {24'h000000, insync_pkg::RST_SYNC_COUNT};
            insync_pkg::OFS_MODE:       r_nxt.rdata = {16'h0000, r_r.mode};
            insync_pkg::OFS_CYCLE:      r_nxt.rdata = r_r.cycle;
            insync_pkg::OFS_SHIFT:      r_nxt.rdata = r_r.shift;
            insync_pkg::OFS_MODES_SUP:  r_nxt.rdata = {16'h0000, insync_pkg::RST_MODES_SUP};
            insync_pkg::OFS_MIN_CYCLE:  r_nxt.rdata = insync_pkg::RST_MIN_CYCLE;
            insync_pkg::OFS_CALC_COPY:  r_nxt.rdata = r_r.calc;
            insync_pkg::OFS_MIN_DELAY:  r_nxt.rdata = insync_pkg::RST_MIN_DELAY;
            insync_pkg::OFS_COMMAND:    r_nxt.rdata = {16'h0000, r_r.cmd};
            insync_pkg::OFS_MAX_DELAY:  r_nxt.rdata = r_r.maxd;
            insync_pkg::OFS_MISSED:     r_nxt.rdata = {16'h0000, r_r.missed};
            insync_pkg::OFS_OVERRUN:    r_nxt.rdata = {16'h0000, r_r.overrun};
            insync_pkg::OFS_SHORT:      r_nxt.rdata = {16'h0000, r_r.short_cnt};
            insync_pkg::OFS_SYNC_ERR:   r_nxt.rdata = {31'h00000000, r_r.sync_err};
            insync_pkg::OFS_IRQ_STATUS: r_nxt.rdata = {28'h0000000, r_r.irq_st};
            insync_pkg::OFS_IRQ_MASK:   r_nxt.rdata = {28'h0000000, r_r.irq_mk};
            default:                    r_nxt.rdata = '0;
         endcase
      end
   end

   // ****************************************
   // registers
   // ****************************************
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         r_r           <= '0;
         r_r.pdo_entry <= insync_pkg::RST_PDO_ENTRY;
         r_r.mode      <= insync_pkg::RST_MODE;
         r_r.cycle     <= insync_pkg::RST_CYCLE;
         r_r.shift     <= insync_pkg::RST_SHIFT;
         r_r.calc      <= insync_pkg::RST_CALC_COPY;
         r_r.maxd      <= insync_pkg::RST_MAX_DELAY;
         r_r.cmd       <= insync_pkg::RST_COMMAND;
      end else begin
         r_r <= r_nxt;
      end
   end

   // ****************************************
   // outputs
   // ****************************************
   // read data is not registered; pready is constant, so the master samples
   // prdata at the access edge, and a registered copy would arrive one edge
   // late, hence prdata is the combinational next value r_nxt.rdata: data is live
   always_comb begin
      prdata      = r_nxt.rdata;
      pslverr     = psel & penable & ~mapped;
      measuring_o = (r_r.cmd == insync_pkg::CMD_START);
      irq_o       = |(r_r.irq_st & r_r.irq_mk);
   end

   // ****************************************
   // assertions
   // ****************************************
   AST_MODE_WRITE: assert property (@(posedge clk_i) disable iff (rst_i)
      (wr && addr == insync_pkg::OFS_MODE) |=> r_r.mode == $past(pwdata[15:0]))
      else $error("sync mode write not stored");
   AST_MEAS_CLEAR: assert property (@(posedge clk_i) disable iff (rst_i)
      (wr && addr == insync_pkg::OFS_COMMAND && pwdata[15:0] == insync_pkg::CMD_START
       && r_r.cmd != insync_pkg::CMD_START) |=> (r_r.shift == 0 && r_r.maxd == 0))
      else $error("measurement start did not clear maxima");
   AST_MEAS_ON: assert property (@(posedge clk_i) disable iff (rst_i)
      (wr && addr == insync_pkg::OFS_COMMAND) |=> measuring_o == ($past(pwdata[15:0]) == 1))
      else $error("measuring flag wrong after command");
   AST_SHORT_CNT: assert property (@(posedge clk_i) disable iff (rst_i)
      (dc && s1 && r_r.t0 < insync_pkg::RST_MIN_DELAY && r_r.short_cnt != 16'hFFFF)
      |=> r_r.short_cnt == $past(r_r.short_cnt) + 16'h0001)
      else $error("short spacing not counted");
   AST_SYNC_ERR: assert property (@(posedge clk_i) disable iff (rst_i)
      (dc && ol) |=> r_r.sync_err)
      else $error("sync error flag not set");
   AST_MISSED_DC: assert property (@(posedge clk_i) disable iff (rst_i)
      !dc |=> r_r.missed == $past(r_r.missed))
      else $error("missed counter moved outside dc mode");
   AST_OVR_OP: assert property (@(posedge clk_i) disable iff (rst_i)
      !op |=> r_r.overrun == $past(r_r.overrun))
      else $error("overrun counted outside operational");
   AST_CONST_RD: assert property (@(posedge clk_i) disable iff (rst_i)
      (rd && addr == insync_pkg::OFS_MODES_SUP) |-> prdata == 32'h00008001)
      else $error("supported modes readback wrong");
endmodule

// *** testbench/insync_master_model.sv ***
// partner model: apb master that configures the bank as the fieldbus master would
`timescale 1ns/10ps
module insync_master_model (
   input  wire logic        clk_i,    // system clock
   output logic             psel,     // apb select
   output logic             penable,  // apb access phase
   output logic             pwrite,   // apb direction
   output logic [7:0]       paddr,    // apb byte address
   output logic [31:0]      pwdata,   // apb write data
   input  wire logic [31:0] prdata,   // apb read data
   input  wire logic        pready,   // apb ready
   input  wire logic        pslverr   // apb error
);
   // ****************************************
   // idle bus at time zero
   // ****************************************
   initial begin
      psel    = 1'b0;
      penable = 1'b0;
      pwrite  = 1'b0;
      paddr   = 8'h00;
      pwdata  = 32'h00000000;
   end
   // one transfer: setup, then access held until pready is seen high
   task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic err);
      @(posedge clk_i);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk_i);
      penable <= 1'b1;
      do @(posedge clk_i); while (pready !== 1'b1);
      q   = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      // released lines show no stale value, so a slave cannot lean on them
      paddr   <= ~a;
      pwdata  <= ~d;
   endtask
endmodule

// *** testbench/tb_input_sync_parameter_bank.sv ***
// testbench: self-checking bench of the input sync parameter bank
`timescale 1ns/10ps
module tb_input_sync_parameter_bank;
   logic        clk_i, rst_i, psel, penable, pwrite, pready, pslverr;   // clock, reset, apb
   logic [7:0]  paddr;                                                 // apb address
   logic [31:0] pwdata, prdata, q, rnd;                                // data, read, random
   logic        op_st, sync0, sync1, sm_ev, samp, avail, late;        // event pins
   logic        meas, irq, err;                                        // observed outputs
   int          fail_count, n_compared, cyc;                           // bookkeeping
   logic [7:0]  ofs [18] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C, 8'h20,
                             8'h24, 8'h28, 8'h2C, 8'h30, 8'h34, 8'h38, 8'h3C, 8'h40, 8'h44};
   logic [31:0] rv [18] = '{32'h01, 32'h1A00, 32'h20, 32'h0, 32'h000F4240, 32'h384, 32'h8001,
                            32'h2710, 32'h0, 32'h384, 32'h0, 32'h384, 32'h0, 32'h0, 32'h0,
                            32'h0, 32'h0, 32'h0};
   logic [17:0] ro = 18'b001111101111100101;                           // read-only entries
   logic [15:0] modes [5] = '{16'h0000, 16'h0001, 16'h0002, 16'h0003, 16'h0022};
   input_sync_parameter_bank input_sync_parameter_bank_i (.clk_i(clk_i), .rst_i(rst_i),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .op_state_i(op_st),
      .sync0_i(sync0), .sync1_i(sync1), .sm_event_i(sm_ev), .sample_i(samp),
      .avail_i(avail), .out_late_i(late), .measuring_o(meas), .irq_o(irq));
   insync_master_model insync_master_model_i (.clk_i(clk_i), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr));
   // ****************************************
   // clock and hang guard
   // ****************************************
   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end
   // the run needs about 500 cycles; far beyond that means a hang
   always @(posedge clk_i) begin
      cyc++;
      if (cyc == 20000) begin
         fail_count++;
         summarize();
      end
   end
   // ****************************************
   // helpers
   // ****************************************
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         fail_count++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic rd(input logic [7:0] a);
      insync_master_model_i.xfer(1'b0, a, 32'h0, q, err);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      insync_master_model_i.xfer(1'b1, a, d, q, err);
   endtask
   // a pin held for four cycles so the two-flop synchroniser sees it
   task automatic pulse(input int k);
      @(posedge clk_i);
      case (k)
         0: sync0 <= 1'b1;
         1: sync1 <= 1'b1;
         2: sm_ev <= 1'b1;
         3: late <= 1'b1;
         4: samp <= 1'b1;
         default: avail <= 1'b1;
      endcase
      repeat (4) @(posedge clk_i);
      {sync0, sync1, sm_ev, late, samp, avail} <= '0;
   endtask
   task automatic summarize();
      $display("compared %0d mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   // ****************************************
   // main sequence
   // ****************************************
   initial begin
      {rst_i, op_st, sync0, sync1, sm_ev, samp, avail, late} = 8'h80;
      rnd = 32'h4181;
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b0;
      // reset values, then writes to read-only entries must not stick
      for (int p = 0; p < 2; p++) begin
         for (int i = 0; i < 18; i++) begin
            if (p == 1 && ro[i]) wr(ofs[i], ~rv[i]);
            rd(ofs[i]);
            check("table entry", q, rv[i]);
         end
      end
      $display("test reset and read-only done");
      // every mode code with random cycle and assignment values
      for (int i = 0; i < 5; i++) begin
         rnd = lfsr(rnd);
         wr(insync_pkg::OFS_MODE, {16'h0, modes[i]});
         wr(insync_pkg::OFS_CYCLE, rnd | 32'h00010000);
         wr(insync_pkg::OFS_PDO_ENTRY, {16'h0, rnd[15:0]});
         rd(insync_pkg::OFS_MODE);
         check("mode", q, {16'h0, modes[i]});
         rd(insync_pkg::OFS_CYCLE);
         check("cycle", q, rnd | 32'h00010000);
         rd(insync_pkg::OFS_PDO_ENTRY);
         check("assign entry", q, {16'h0, rnd[15:0]});
      end
      // unmapped addresses answer with an error and zero data
      wr(8'h48, 32'hFFFFFFFF);
      check("error on write", {31'h0, err}, 32'h1);
      rd(8'hFC);
      check("error on read", {31'h0, err}, 32'h1);
      check("unmapped data", q, 32'h0);
      $display("test registers done");
      // measurement start and stop
      wr(insync_pkg::OFS_COMMAND, 32'h1);
      @(negedge clk_i);
      check("measuring", {31'h0, meas}, 32'h1);
      rd(insync_pkg::OFS_CALC_COPY);
      check("calc copy cleared", q, 32'h0);
      rd(insync_pkg::OFS_SHIFT);
      check("shift cleared", q, 32'h0);
      pulse(4);
      pulse(5);
      wr(insync_pkg::OFS_COMMAND, 32'h0);
      @(negedge clk_i);
      check("stopped", {31'h0, meas}, 32'h0);
      $display("test measurement done");
      // dc cycle of 1000 ns, short interrupt only unmasked
      wr(insync_pkg::OFS_CYCLE, 32'd1000);
      wr(insync_pkg::OFS_MODE, 32'h2);
      wr(insync_pkg::OFS_IRQ_MASK, 32'h4);
      op_st <= 1'b1;
      pulse(0);
      pulse(3);
      repeat (4) @(posedge clk_i);
      check("masked irq", {31'h0, irq}, 32'h0);
      rd(insync_pkg::OFS_SYNC_ERR);
      check("sync error", q, 32'h1);
      pulse(1);
      repeat (5) @(posedge clk_i);
      check("short irq", {31'h0, irq}, 32'h1);
      pulse(2);
      repeat (40) @(posedge clk_i);
      pulse(0);
      repeat (95) @(posedge clk_i);
      pulse(0);
      repeat (6) @(posedge clk_i);
      rd(insync_pkg::OFS_SYNC_ERR);
      check("sync error cleared", q, 32'h0);
      rd(insync_pkg::OFS_MISSED);
      check("missed count", q, 32'h1);
      rd(insync_pkg::OFS_SHORT);
      check("short count", q, 32'h1);
      wr(insync_pkg::OFS_IRQ_STATUS, 32'hF);
      repeat (3) @(posedge clk_i);
      check("irq cleared", {31'h0, irq}, 32'h0);
      rd(insync_pkg::OFS_IRQ_STATUS);
      check("short status", {31'h0, q[2]}, 32'h0);
      $display("test events done");
      summarize();
   end
endmodule
